// ---- dv/serial_link_stream_user_port_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_link_stream_user_port_bench;
  import stream_port_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic chanTxReady = 1'b0, chanTxValid, chanTxStart, chanTxEnd, chanTxPad, rxFrameError;
  data_type chanTxData, recvData;
  keep_type chanTxKeep, recvKeep;
  data_type chanRxData = 16'h0000, sendData = 16'h0000;
  keep_type chanRxKeep = 2'h0, sendKeep = 2'h0;
  logic chanRxValid = 1'b0, chanRxEnd = 1'b0, sendLast = 1'b0, sendValid = 1'b0;
  logic sendReady, recvLast, recvValid, prevEnd = 1'b0, first = 1'b1;
  logic [31:0] seedA = 32'h6d9f;
  logic [31:0] seedB = 32'h6d9f;
  logic [18:0] txQ[$], rxQ[$], t;
  int failures = 0;
  int n_tests = 0;
  int bytes = 0;
  // Second pair: streaming build with mirrored bit order
  logic chanTxValid2, chanTxStart2, chanTxEnd2, chanTxPad2, rxFrameError2, sendReady2;
  logic recvLast2, recvValid2;
  data_type chanTxData2, recvData2;
  keep_type chanTxKeep2, recvKeep2;
  data_type txQ2[$], rxQ2[$];

  always #12.5 clk = ~clk;

  user_stream_if i_user_stream_if (.clk(clk));
  stream_port_device i_stream_port_device (.clk(clk), .reset_n(reset_n),
    .port(i_user_stream_if.device), .chanTxReady(chanTxReady), .chanTxData(chanTxData),
    .chanTxValid(chanTxValid), .chanTxStart(chanTxStart), .chanTxEnd(chanTxEnd),
    .chanTxPad(chanTxPad), .chanTxKeep(chanTxKeep), .chanRxData(chanRxData),
    .chanRxValid(chanRxValid), .chanRxEnd(chanRxEnd), .chanRxKeep(chanRxKeep),
    .rxFrameError(rxFrameError));
  stream_port_user i_stream_port_user (.clk(clk), .reset_n(reset_n),
    .port(i_user_stream_if.user), .sendData(sendData), .sendKeep(sendKeep),
    .sendLast(sendLast), .sendValid(sendValid), .sendReady(sendReady), .recvData(recvData),
    .recvKeep(recvKeep), .recvLast(recvLast), .recvValid(recvValid));
  serial_link_stream_user_port_chk i_chk (.clk(clk), .reset_n(reset_n),
    .txData(i_user_stream_if.txData), .txKeep(i_user_stream_if.txKeep),
    .txLast(i_user_stream_if.txLast), .txValid(i_user_stream_if.txValid),
    .txReady(i_user_stream_if.txReady), .rxData(i_user_stream_if.rxData),
    .rxKeep(i_user_stream_if.rxKeep), .rxLast(i_user_stream_if.rxLast),
    .rxValid(i_user_stream_if.rxValid));
  user_stream_if i_user_stream_if_stream (.clk(clk));
  stream_port_device #(.FRAMING(1'b0), .ASCENDING(1'b1)) i_stream_port_device_stream (
    .clk(clk), .reset_n(reset_n), .port(i_user_stream_if_stream.device),
    .chanTxReady(chanTxReady), .chanTxData(chanTxData2), .chanTxValid(chanTxValid2),
    .chanTxStart(chanTxStart2), .chanTxEnd(chanTxEnd2), .chanTxPad(chanTxPad2),
    .chanTxKeep(chanTxKeep2), .chanRxData(chanRxData), .chanRxValid(chanRxValid),
    .chanRxEnd(chanRxEnd), .chanRxKeep(chanRxKeep), .rxFrameError(rxFrameError2));
  stream_port_user #(.FRAMING(1'b0)) i_stream_port_user_stream (
    .clk(clk), .reset_n(reset_n), .port(i_user_stream_if_stream.user),
    .sendData(sendData), .sendKeep(sendKeep), .sendLast(sendLast), .sendValid(sendValid),
    .sendReady(sendReady2), .recvData(recvData2), .recvKeep(recvKeep2),
    .recvLast(recvLast2), .recvValid(recvValid2));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected word on a bus with the mirrored index order
  function automatic data_type mirror(input data_type d);
    data_type r;
    for (int i = 0; i < 16; i++) r[i] = d[15 - i];
    return r;
  endfunction : mirror

  task automatic fail(input string msg);
    failures++;
    $display("FAIL %0t %s", $time, msg);
  endtask : fail

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic send(input data_type d, input keep_type k, input logic l);
    int n = 0;
    sendData = d;
    sendKeep = k;
    sendLast = l;
    sendValid = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (sendReady !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail("send stalled");
      complete_run();
    end
    #1;
  endtask : send

  // Lane side: random stalls, words and gaps; frame ends never in adjacent cycles
  always @(posedge clk) begin
    #1;
    seedB = lfsr(seedB);
    chanTxReady = run && seedB[1:0] != 2'b00;
    chanRxValid = run && seedB[2];
    chanRxEnd = seedB[3] && !prevEnd;
    chanRxKeep = seedB[4] ? 2'h3 : 2'h1;
    chanRxData = seedB[20:5];
    prevEnd = chanRxValid && chanRxEnd;
  end

  always @(posedge clk) begin
    if (reset_n) begin
      if (sendValid && sendReady) txQ.push_back({sendLast, sendLast ? sendKeep : 2'h3, sendData});
      if (chanRxValid) rxQ.push_back({chanRxEnd, chanRxEnd ? chanRxKeep : 2'h0, chanRxData});
      if (sendValid && sendReady2) txQ2.push_back(mirror(sendData));
      if (chanRxValid) rxQ2.push_back(mirror(chanRxData));
      if (chanTxValid) begin
        t = txQ.pop_front();
        bytes += t[18] ? int'(t[16]) + int'(t[17]) : 2;
        n_tests += 2;
        if ({chanTxEnd, chanTxKeep, chanTxData, chanTxStart} !== {t, first}) fail("tx beat");
        if (t[18] && chanTxPad !== bytes[0]) fail("tx pad");
        if (t[18]) bytes = 0;
        first = t[18];
      end
      if (recvValid) begin
        n_tests++;
        if ({recvLast, recvKeep, recvData} !== rxQ.pop_front()) fail("rx word");
      end
      if (chanTxValid2) begin
        n_tests++;
        if ({chanTxEnd2, chanTxStart2, chanTxPad2, chanTxKeep2, chanTxData2}
            !== {3'b000, 2'h3, txQ2.pop_front()}) fail("stream tx beat");
      end
      if (recvValid2) begin
        n_tests++;
        if ({recvLast2, recvKeep2, recvData2}
            !== {3'b000, rxQ2.pop_front()}) fail("stream rx word");
      end
      if ({rxFrameError, rxFrameError2} !== 2'b00) fail("frame error flag");
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 run = 1'b1;
    send(16'h1234, 2'h1, 1'b1);
    send(16'habcd, 2'h3, 1'b1);
    for (int i = 0; i < 400; i++) begin
      seedA = lfsr(seedA);
      send(seedA[15:0], seedA[16] ? 2'h3 : 2'h1, seedA[19:17] == 3'h0);
      if (seedA[20]) begin
        sendValid = 1'b0;
        @(posedge clk);
        #1;
      end
    end
    sendValid = 1'b0;
    // Keep the lane running until every loaded beat has gone out
    for (int i = 0; i < 200 && (txQ.size() != 0 || txQ2.size() != 0); i++) @(posedge clk);
    #1 run = 1'b0;
    repeat (8) @(posedge clk);
    n_tests++;
    if (txQ.size() + txQ2.size() + rxQ.size() + rxQ2.size() != 0) fail("words left undelivered");
    complete_run();
  end
endmodule : serial_link_stream_user_port_bench
`default_nettype wire

// ---- dv/serial_link_stream_user_port_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_link_stream_user_port_chk
  import stream_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Transmit stream
  input wire data_type txData,
  input wire keep_type txKeep,
  input wire logic txLast,
  input wire logic txValid,
  input wire logic txReady,
  // Receive stream
  input wire data_type rxData,
  input wire keep_type rxKeep,
  input wire logic rxLast,
  input wire logic rxValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  rx_last_valid_a: assert property (rxLast |-> rxValid)
    else $error("rx last without valid");
  // The bench never ends two frames in adjacent cycles, so a second cycle is a stretch
  rx_last_pulse_a: assert property (rxLast |=> !rxLast)
    else $error("rx last held");
  rx_keep_last_a: assert property (rxKeep != 2'h0 |-> rxLast)
    else $error("rx keep outside last");
  rx_last_keep_a: assert property (rxLast |-> rxKeep inside {2'h1, 2'h3})
    else $error("rx keep count wrong");
  tx_last_gap_a: assert property (txValid && txReady && txLast |=> !txReady)
    else $error("tx ready not dropped after last");
  tx_hold_valid_a: assert property (txValid && !txReady |=> txValid)
    else $error("tx valid withdrawn");
  tx_hold_data_a: assert property (txValid && !txReady |=> $stable({txData, txKeep, txLast}))
    else $error("tx beat changed while stalled");
  tx_keep_pack_a: assert property (txValid && txLast |-> txKeep inside {2'h1, 2'h3})
    else $error("tx keep not packed");

  cover property (txValid && txReady && txLast);
  cover property (txValid && !txReady);
  cover property (rxLast && rxKeep == 2'h1);
endmodule : serial_link_stream_user_port_chk
`default_nettype wire

// ---- logic/stream_port_cfg.svh ----
`ifndef STREAM_PORT_CFG_SVH
`define STREAM_PORT_CFG_SVH
`define LANE_COUNT 1
`define LANE_BYTES 2
`define BYTE_COUNT (`LANE_COUNT * `LANE_BYTES)
`define DATA_WIDTH (8 * `BYTE_COUNT)
`define FRAMING_DEFAULT 1'b1
`define ASCENDING_DEFAULT 1'b0
`define READY_RESET 1'b0
`define KEEP_FULL 2'h3
`endif

// ---- logic/stream_port_device.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "stream_port_cfg.svh"
module stream_port_device #(
  parameter bit FRAMING = `FRAMING_DEFAULT,
  parameter bit ASCENDING = `ASCENDING_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User stream end
  user_stream_if.device port,
  // Lane logic, transmit
  input wire logic chanTxReady,
  output logic [`DATA_WIDTH-1:0] chanTxData,
  output logic chanTxValid,
  output logic chanTxStart,
  output logic chanTxEnd,
  output logic chanTxPad,
  output logic [`BYTE_COUNT-1:0] chanTxKeep,
  // Lane logic, receive
  input wire logic [`DATA_WIDTH-1:0] chanRxData,
  input wire logic chanRxValid,
  input wire logic chanRxEnd,
  input wire logic [`BYTE_COUNT-1:0] chanRxKeep,
  output logic rxFrameError
);
  import stream_port_pkg::*;

  // Number of set bits; used for byte counts on both paths
  function automatic logic [7:0] countBytes(input keep_type k);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < `BYTE_COUNT; i++) begin
      c = c + {7'h00, k[i]};
    end
    return c;
  endfunction : countBytes

  // Ascending option mirrors the bus so index 0 holds the MSB
  function automatic data_type orderBits(input data_type d, input bit asc);
    data_type r;
    r = d;
    if (asc) begin
      for (int i = 0; i < `DATA_WIDTH; i++) begin
        r[i] = d[`DATA_WIDTH-1-i];
      end
    end
    return r;
  endfunction : orderBits

  // Transmit path
  tx_state_type txState_reg, txState_next;
  logic txReady_reg, txReady_next;
  logic oddBytes_reg, oddBytes_next;
  data_type chanTxData_reg;
  keep_type chanTxKeep_reg;
  logic chanTxValid_reg;
  logic chanTxStart_reg;
  logic chanTxEnd_reg;
  logic chanTxPad_reg;

  wire logic txAccept = port.txValid && txReady_reg;
  wire logic txLastUsed = FRAMING && port.txLast;
  // Keep is ignored unless the beat closes a frame
  wire keep_type txKeepUsed = txLastUsed ? port.txKeep : `KEEP_FULL;
  wire logic [7:0] beatBytes = countBytes(txKeepUsed);
  wire logic frameOdd = oddBytes_reg ^ beatBytes[0];
  wire data_type txWord = orderBits(port.txData, ASCENDING);
  wire logic txFirst = txAccept && FRAMING && (txState_reg == TX_IDLE);
  wire logic txEndNow = txAccept && txLastUsed;
  // A single-beat frame has no running total yet, so its own count decides
  wire logic txPadNow = txEndNow && (txState_reg == TX_IDLE ? beatBytes[0] : frameOdd);

  always_comb begin
    txState_next = txState_reg;
    oddBytes_next = oddBytes_reg;
    case (txState_reg)
      TX_IDLE: begin
        if (txAccept) begin
          txState_next = txLastUsed ? TX_CLOSE : TX_FRAME;
          oddBytes_next = txLastUsed ? 1'b0 : beatBytes[0];
        end
      end
      TX_FRAME: begin
        if (txAccept) begin
          txState_next = txLastUsed ? TX_CLOSE : TX_FRAME;
          oddBytes_next = txLastUsed ? 1'b0 : frameOdd;
        end
      end
      TX_CLOSE: begin
        // One dead cycle sends the trailing bytes and the end marker
        txState_next = TX_IDLE;
      end
      default: begin
        txState_next = TX_IDLE;
      end
    endcase
  end

  // Ready is registered, so it trails the lane's ready by one cycle; the lane
  // side must still take two words after it drops its own ready.
  // After a last beat ready stays low for exactly the close cycle.
  assign txReady_next = chanTxReady && !txEndNow && (txState_next != TX_CLOSE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txState_reg <= TX_IDLE;
      txReady_reg <= `READY_RESET;
      oddBytes_reg <= 1'b0;
    end else begin
      txState_reg <= txState_next;
      txReady_reg <= txReady_next;
      oddBytes_reg <= oddBytes_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chanTxData_reg <= '0;
      chanTxKeep_reg <= '0;
      chanTxValid_reg <= 1'b0;
      chanTxStart_reg <= 1'b0;
      chanTxEnd_reg <= 1'b0;
      chanTxPad_reg <= 1'b0;
    end else begin
      chanTxValid_reg <= txAccept;
      if (txAccept) begin
        chanTxData_reg <= txWord;
        chanTxKeep_reg <= txKeepUsed;
      end
      chanTxStart_reg <= txFirst;
      chanTxEnd_reg <= txEndNow;
      chanTxPad_reg <= txPadNow;
    end
  end

  assign port.txReady = txReady_reg;
  assign chanTxData = chanTxData_reg;
  assign chanTxKeep = chanTxKeep_reg;
  assign chanTxValid = chanTxValid_reg;
  assign chanTxStart = chanTxStart_reg;
  assign chanTxEnd = chanTxEnd_reg;
  assign chanTxPad = chanTxPad_reg;

  // Receive path: no ready exists, every word goes straight out
  rx_state_type rxState_reg, rxState_next;
  data_type rxData_reg;
  keep_type rxKeep_reg;
  logic rxLast_reg;
  logic rxValid_reg;
  logic rxFrameError_reg;

  // A streaming build never sees an end, so last and keep stay low there
  wire logic rxEndUsed = FRAMING && chanRxValid && chanRxEnd;
  wire keep_type rxKeepWord = rxEndUsed ? chanRxKeep : '0;
  // An end with zero bytes cannot be shown and is flagged
  wire logic rxEmptyEnd = rxEndUsed && (countBytes(chanRxKeep) == 8'h00);
  // Received words get the same mirroring as transmitted ones
  wire data_type rxWord = orderBits(chanRxData, ASCENDING);

  always_comb begin
    rxState_next = rxState_reg;
    case (rxState_reg)
      RX_IDLE: begin
        if (chanRxValid && FRAMING && !chanRxEnd) begin
          rxState_next = RX_FRAME;
        end
      end
      RX_FRAME: begin
        if (rxEndUsed) begin
          rxState_next = RX_IDLE;
        end
      end
      default: begin
        rxState_next = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxState_reg <= RX_IDLE;
      rxData_reg <= '0;
      rxKeep_reg <= '0;
      rxLast_reg <= 1'b0;
      rxValid_reg <= 1'b0;
      rxFrameError_reg <= 1'b0;
    end else begin
      rxState_reg <= rxState_next;
      rxValid_reg <= chanRxValid;
      if (chanRxValid) begin
        rxData_reg <= rxWord;
      end
      rxLast_reg <= rxEndUsed;
      rxKeep_reg <= rxKeepWord;
      rxFrameError_reg <= rxEmptyEnd;
    end
  end

  assign port.rxData = rxData_reg;
  assign port.rxKeep = rxKeep_reg;
  assign port.rxLast = rxLast_reg;
  assign port.rxValid = rxValid_reg;
  assign rxFrameError = rxFrameError_reg;

endmodule : stream_port_device
`default_nettype wire

// ---- logic/stream_port_pkg.sv ----
`default_nettype none
`include "stream_port_cfg.svh"
package stream_port_pkg;
  typedef logic [`DATA_WIDTH-1:0] data_type;
  typedef logic [`BYTE_COUNT-1:0] keep_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FRAME = 2'b01,
    TX_CLOSE = 2'b10
  } tx_state_type;
  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_FRAME = 1'b1
  } rx_state_type;
endpackage : stream_port_pkg
`default_nettype wire

// ---- logic/stream_port_user.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "stream_port_cfg.svh"
module stream_port_user #(
  parameter bit FRAMING = `FRAMING_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Stream toward the device
  user_stream_if.user port,
  // Application send side
  input wire logic [`DATA_WIDTH-1:0] sendData,
  input wire logic [`BYTE_COUNT-1:0] sendKeep,
  input wire logic sendLast,
  input wire logic sendValid,
  output logic sendReady,
  // Application receive side
  output logic [`DATA_WIDTH-1:0] recvData,
  output logic [`BYTE_COUNT-1:0] recvKeep,
  output logic recvLast,
  output logic recvValid
);
  import stream_port_pkg::*;

  // Packs the same number of bytes from the LSB upward
  function automatic keep_type packKeep(input keep_type k);
    keep_type r;
    r = '0;
    for (int i = 0; i < `BYTE_COUNT; i++) begin
      if (k[i]) begin
        r = {r[`BYTE_COUNT-2:0], 1'b1};
      end
    end
    return r;
  endfunction : packKeep

  data_type txData_reg;
  keep_type txKeep_reg;
  logic txLast_reg, txValid_reg, sendReady_reg;
  data_type recvData_reg;
  keep_type recvKeep_reg;
  logic recvLast_reg, recvValid_reg;

  wire logic handed = txValid_reg && port.txReady;
  wire logic slotFree = !txValid_reg || handed;
  wire logic load = sendValid && sendReady_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txData_reg <= '0;
      txKeep_reg <= '0;
      txLast_reg <= 1'b0;
      txValid_reg <= 1'b0;
      sendReady_reg <= 1'b0;
    end else begin
      if (load) begin
        txValid_reg <= 1'b1;
        txData_reg <= sendData;
        txLast_reg <= FRAMING && sendLast;
        txKeep_reg <= (FRAMING && sendLast) ? packKeep(sendKeep) : `KEEP_FULL;
      end else if (handed) begin
        txValid_reg <= 1'b0;
      end
      // One holding slot; the next beat waits until this one is taken
      sendReady_reg <= slotFree && !load;
    end
  end

  // Every valid beat is taken, since the device cannot be stalled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      recvData_reg <= '0;
      recvKeep_reg <= '0;
      recvLast_reg <= 1'b0;
      recvValid_reg <= 1'b0;
    end else begin
      recvValid_reg <= port.rxValid;
      recvData_reg <= port.rxData;
      recvLast_reg <= port.rxValid && port.rxLast;
      recvKeep_reg <= (port.rxValid && port.rxLast) ? port.rxKeep : '0;
    end
  end

  assign port.txData = txData_reg;
  assign port.txKeep = txKeep_reg;
  assign port.txLast = txLast_reg;
  assign port.txValid = txValid_reg;
  assign sendReady = sendReady_reg;
  assign recvData = recvData_reg;
  assign recvKeep = recvKeep_reg;
  assign recvLast = recvLast_reg;
  assign recvValid = recvValid_reg;

endmodule : stream_port_user
`default_nettype wire

// ---- logic/user_stream_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface user_stream_if (
  input wire logic clk
);
  import stream_port_pkg::*;
  data_type txData;
  keep_type txKeep;
  logic txLast;
  logic txValid;
  logic txReady;
  data_type rxData;
  keep_type rxKeep;
  logic rxLast;
  logic rxValid;
  modport device (
    input clk, txData, txKeep, txLast, txValid,
    output txReady, rxData, rxKeep, rxLast, rxValid
  );
  modport user (
    input clk, txReady, rxData, rxKeep, rxLast, rxValid,
    output txData, txKeep, txLast, txValid
  );
endinterface : user_stream_if
`default_nettype wire
